// *** rtl/lpws_top.sv ***
// low power wake sequencer: wait/stop exit, vectors, recovery, supply monitor
//
// Notes on behaviour
// R1 - wake timer runs in stop only with oscillator
// R2 - can runs in wait, registers blocked
// R3 - can inactive in stop, registers kept
// R4 - wait wake restarts cpu clock, loads vector
// R5 - pin, watchdog, supply resets use reset vector
// R6 - irq pin falling edge wakes, vector FFFA
// R7 - emulation break ends wait, vector FFFC
// R8 - clock generator FFF8, keypad FFE0, keypad wakes stop
// R9 - first timer vectors FFF2, FFF4, FFF6
// R10 - second timer vectors FFEC, FFEE, FFF0
// R11 - serial peripheral vectors FFE8, FFEA
// R12 - async serial vectors FFE2, FFE4, FFE6
// R13 - converter FFDE, wake timer FFDC
// R14 - can vectors FFD4, FFD6, FFD8, FFDA
// R15 - only listed sources end stop
// R16 - wake timer rollover wakes from stop
// R17 - can wakes stop, receive waits for sync
// R18 - recovery holds clocks 4096 cycles
// R19 - short recovery bit gives 32 cycles
// R20 - monitor enable, reset, stop, trip bits
// R21 - supply reset held, reset pin driven low
// R22 - trip level 3 V at power on
// R23 - supply low flag with hysteresis
// R24 - events during recovery kept pending
`timescale 1ns/1ns
`default_nettype none
module lpws_top
  import lpws_pkg::*;
#(
  parameter int REC_LONG = REC_LONG_CYC, // long recovery count
  parameter int REC_SHORT = REC_SHORT_CYC // short recovery count
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic reset_pin_in_n,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic watchdog_timeout,
  input wire logic emulation_mode,
  input wire logic irq_pin,
  input wire logic [SRC_N-1:0] irq_req,
  input wire logic cpu_wait_req,
  input wire logic cpu_stop_req,
  input wire logic can_sync_ok,
  input wire logic cmp_below_falling,
  input wire logic cmp_above_rising,
  output logic cpu_clk_en,
  output logic sys_clk_en,
  output logic vector_load,
  output logic [15:0] vector_addr,
  output logic device_reset,
  output logic pwt_run,
  output logic pwt_reg_access,
  output logic can_active,
  output logic can_reg_access,
  output logic can_rx_enable,
  output logic supply_monitor_enable,
  output logic trip_level_select,
  output logic osc_run_in_stop
);

  ////////////////////////////////////////////////////////////////////
  // state
  lpws_state_t state, next_state; // sequencer mode
  logic from_stop, next_from_stop; // reset taken while stopped or recovering
  logic rst_pend, next_rst_pend; // reset vector owed after recovery
  logic [REC_W-1:0] rec_cnt, next_rec_cnt; // recovery down counter
  logic [SRC_N-1:0] pend, next_pend; // latched wake events
  logic irq_prev; // last irq pin sample
  logic [CTRL_W-1:0] ctrl, next_ctrl; // software control bits
  logic supply_low, next_supply_low; // comparator flag
  logic hold, next_hold; // supply reset in force
  logic [15:0] next_vec; // vector to present
  logic next_ld; // vector load strobe
  // combinational helpers
  logic irq_fall; // falling edge on irq pin
  logic [SRC_N-1:0] req; // eligible requests this cycle
  logic [SRC_N-1:0] avail; // pending or new
  logic [SRC_N-1:0] clr; // served bit
  logic [SRC_N-1:0] stop_mask; // stop wake sources
  logic found; // some source wants service
  logic [4:0] sel; // chosen source
  logic mon_en; // monitor active now
  logic rst_src; // any reset source
  logic flush; // drop pending events
  logic [REC_W-1:0] rec_load; // recovery start value
  logic wr_en; // bus write strobe
  logic [ADDR_W-1:0] wr_addr; // bus write address
  logic [31:0] wr_data; // bus write data
  logic [3:0] wr_strb; // bus write lanes

  ////////////////////////////////////////////////////////////////////
  // next value of the sequencer, pending set and supply monitor
  always_comb begin
    irq_fall = irq_prev & ~irq_pin; // R6
    req = irq_req;
    req[SRC_IRQ] = irq_req[SRC_IRQ] | irq_fall; // R6
    req[SRC_BRK] = irq_req[SRC_BRK] & emulation_mode; // R7
    stop_mask = STOP_WAKE; // R8 R15 R17
    stop_mask[SRC_PWT] = ctrl[CB_OSC]; // R1 R16
    if (state == ST_STOP) begin
      req = req & stop_mask; // R15
    end
    avail = pend | req;
    // lowest index takes priority
    found = 1'b0;
    sel = 5'h00;
    for (int i = SRC_N - 1; i >= 0; i--) begin
      if (avail[i]) begin
        found = 1'b1;
        sel = 5'(i);
      end
    end
    // supply monitor
    mon_en = ~ctrl[CB_PWRD] & ((state != ST_STOP) | ctrl[CB_STOPEN]); // R20
    next_supply_low = supply_low; // R23
    if (mon_en && cmp_below_falling) begin
      next_supply_low = 1'b1; // R23
    end else if (mon_en && cmp_above_rising) begin
      next_supply_low = 1'b0; // R23
    end
    rst_src = ~reset_pin_in_n | watchdog_timeout | hold; // R5
    rec_load = ctrl[CB_SSR] ? REC_W'(REC_SHORT - 1) : REC_W'(REC_LONG - 1); // R18 R19
    // defaults
    next_state = state;
    next_from_stop = from_stop;
    next_rst_pend = rst_pend;
    next_rec_cnt = rec_cnt;
    next_vec = vector_addr;
    next_ld = 1'b0;
    clr = '0;
    flush = 1'b0;
    unique case (state)
      ST_RUN: begin
        flush = 1'b1;
        if (cpu_stop_req) begin
          next_state = ST_STOP;
        end else if (cpu_wait_req) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // any eligible source ends wait at once; break only in emulation
        if (found) begin
          next_ld = 1'b1; // R4
          next_vec = VEC_TAB[sel]; // R6 R7 R8 R9 R10 R11 R12 R13 R14
          clr[sel] = 1'b1;
          next_state = ST_RUN; // R4
        end
      end
      ST_STOP: begin
        // only stop wake sources reach here
        if (found) begin
          next_rec_cnt = rec_load; // R18
          next_state = ST_RECOVER; // R15 R16 R17
        end
      end
      ST_RECOVER: begin
        // clocks stay off; events keep collecting
        if (rec_cnt == '0) begin
          next_state = ST_RUN; // R18
          if (rst_pend) begin
            next_rst_pend = 1'b0;
            next_ld = 1'b1;
            next_vec = VEC_RESET; // R5
          end else if (found) begin
            next_ld = 1'b1; // R24
            next_vec = VEC_TAB[sel]; // R24
            clr[sel] = 1'b1;
          end
        end else begin
          next_rec_cnt = rec_cnt - 1'b1; // R18
        end
      end
      ST_RESET: begin
        flush = 1'b1;
        if (!rst_src) begin
          if (from_stop) begin
            next_from_stop = 1'b0;
            next_rst_pend = 1'b1;
            next_rec_cnt = rec_load; // R18
            next_state = ST_RECOVER;
          end else begin
            next_ld = 1'b1;
            next_vec = VEC_RESET; // R5
            next_state = ST_RUN;
          end
        end
      end
    endcase
    // any reset overrides the sequence
    if (rst_src && state != ST_RESET) begin
      next_state = ST_RESET; // R5 R21
      next_from_stop = (state == ST_STOP) || (state == ST_RECOVER);
      next_rst_pend = 1'b0;
      next_ld = 1'b0;
      next_vec = vector_addr;
    end
    // new event in the serving cycle is kept, except for the served source when its bit was not already pending
    if (flush) begin
      next_pend = '0;
    end else begin
      next_pend = (pend & ~clr) | (req & ~(clr & ~pend)); // R24
    end
    // bus writes to control
    next_ctrl = ctrl;
    if (wr_en && wr_addr == REG_CTRL && wr_strb[0]) begin
      next_ctrl = wr_data[CTRL_W-1:0]; // R20
    end
    // supply reset: set wins over the release
    next_hold = hold;
    if (cmp_above_rising) begin
      next_hold = 1'b0; // R21
    end
    if (mon_en && !ctrl[CB_RSTD] && cmp_below_falling) begin
      next_hold = 1'b1; // R21
    end
    if (mon_en && next_ctrl[CB_TRIP] && !ctrl[CB_TRIP] && !cmp_above_rising) begin
      next_hold = 1'b1; // R22
    end
  end

  // next values of the outputs that follow the sequencer
  logic next_cpu_clk, next_sys_clk, next_pwt_run, next_pwt_acc;
  logic next_can_act, next_can_acc, next_can_rx, next_mon_en;
  always_comb begin
    next_cpu_clk = (next_state == ST_RUN); // R4
    next_sys_clk = (next_state == ST_RUN) || (next_state == ST_WAIT); // R18
    next_pwt_run = (next_state != ST_STOP) || next_ctrl[CB_OSC]; // R1
    next_pwt_acc = (next_state == ST_RUN); // R1
    next_can_act = (next_state != ST_STOP) && (next_state != ST_RECOVER); // R2 R3
    next_can_acc = (next_state == ST_RUN); // R2
    next_can_rx = next_sys_clk && can_sync_ok; // R17
    next_mon_en = ~next_ctrl[CB_PWRD] & ((next_state != ST_STOP) | next_ctrl[CB_STOPEN]);
  end

  // register the sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_RESET;
      from_stop <= 1'b0;
      rst_pend <= 1'b0;
      rec_cnt <= '0;
      pend <= '0;
      irq_prev <= 1'b1;
      ctrl <= CTRL_RESET; // R20 R22
      supply_low <= 1'b0; // R23
      hold <= 1'b0;
      vector_load <= 1'b0;
      vector_addr <= VEC_RESET;
      cpu_clk_en <= 1'b0;
      sys_clk_en <= 1'b0;
      device_reset <= 1'b1;
      pwt_run <= 1'b0;
      pwt_reg_access <= 1'b0;
      can_active <= 1'b0;
      can_reg_access <= 1'b0;
      can_rx_enable <= 1'b0;
      supply_monitor_enable <= 1'b0;
      trip_level_select <= 1'b0;
      osc_run_in_stop <= 1'b0;
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b0;
    end else begin
      state <= next_state;
      from_stop <= next_from_stop;
      rst_pend <= next_rst_pend;
      rec_cnt <= next_rec_cnt;
      pend <= next_pend;
      irq_prev <= irq_pin;
      ctrl <= next_ctrl;
      supply_low <= next_supply_low;
      hold <= next_hold;
      vector_load <= next_ld;
      vector_addr <= next_vec;
      cpu_clk_en <= next_cpu_clk;
      sys_clk_en <= next_sys_clk;
      device_reset <= (next_state == ST_RESET);
      pwt_run <= next_pwt_run;
      pwt_reg_access <= next_pwt_acc;
      can_active <= next_can_act;
      can_reg_access <= next_can_acc;
      can_rx_enable <= next_can_rx;
      supply_monitor_enable <= next_mon_en;
      trip_level_select <= next_ctrl[CB_TRIP];
      osc_run_in_stop <= next_ctrl[CB_OSC];
      reset_pin_out <= 1'b0;
      reset_pin_oe <= next_hold; // R21
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register bus slave
  logic aw_got, next_aw_got; // write address held
  logic w_got, next_w_got; // write data held
  logic [ADDR_W-1:0] aw_q, next_aw_q; // held address
  logic [31:0] w_q, next_w_q; // held data
  logic [3:0] s_q, next_s_q; // held strobes
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  // next value of the bus channels
  always_comb begin
    next_aw_got = aw_got | (awvalid & awready);
    next_w_got = w_got | (wvalid & wready);
    next_aw_q = (awvalid & awready) ? awaddr : aw_q;
    next_w_q = (wvalid & wready) ? wdata : w_q;
    next_s_q = (wvalid & wready) ? wstrb : s_q;
    next_bvalid = bvalid & ~bready;
    next_bresp = bresp;
    wr_en = 1'b0;
    wr_addr = next_aw_q;
    wr_data = next_w_q;
    wr_strb = next_s_q;
    // both halves present and no response waiting
    if (next_aw_got && next_w_got && !bvalid) begin
      wr_en = 1'b1;
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (next_aw_q == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
    end
    next_awready = ~next_aw_got & ~next_bvalid;
    next_wready = ~next_w_got & ~next_bvalid;
    // read side
    next_rvalid = rvalid & ~rready;
    next_rdata = rdata;
    next_rresp = rresp;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rdata = '0;
      next_rresp = RESP_OKAY;
      unique case (araddr)
        REG_CTRL: next_rdata[CTRL_W-1:0] = ctrl;
        REG_STAT: begin
          next_rdata[SB_LOW] = supply_low; // R23
          next_rdata[SB_HOLD] = hold;
          next_rdata[SB_STATE +: 3] = state;
        end
        REG_VEC: next_rdata[15:0] = vector_addr;
        REG_PEND: next_rdata[SRC_N-1:0] = pend;
        default: next_rresp = RESP_DECERR;
      endcase
    end
    next_arready = ~next_rvalid;
  end

  // register the bus channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_q <= '0;
      w_q <= '0;
      s_q <= '0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      aw_q <= next_aw_q;
      w_q <= next_w_q;
      s_q <= next_s_q;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  logic [REC_W:0] rec_seen; // cycles spent in recovery
  logic rec_short; // short recovery chosen at entry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rec_seen <= '0;
      rec_short <= 1'b0;
    end else begin
      rec_seen <= (state == ST_RECOVER) ? rec_seen + 1'b1 : '0;
      if (state != ST_RECOVER) begin
        rec_short <= ctrl[CB_SSR];
      end
    end
  end

  property p_pwt_off;
    @(posedge aclk) disable iff (!aresetn)
      (state == ST_STOP && !ctrl[CB_OSC]) |-> !pwt_run && !pwt_reg_access;
  endproperty
  a_pwt_off: assert property (p_pwt_off) else $error("wake timer active in stop"); // R1

  property p_can_wait;
    @(posedge aclk) disable iff (!aresetn)
      (state == ST_WAIT) |-> can_active && !can_reg_access && !cpu_clk_en;
  endproperty
  a_can_wait: assert property (p_can_wait) else $error("can access in wait"); // R2

  property p_can_stop;
    @(posedge aclk) disable iff (!aresetn)
      (state == ST_STOP) |-> !can_active && !sys_clk_en;
  endproperty
  a_can_stop: assert property (p_can_stop) else $error("can active in stop"); // R3

  property p_reset_vec;
    @(posedge aclk) disable iff (!aresetn)
      (state == ST_RESET && !rst_src && !from_stop)
        |=> vector_load && vector_addr == VEC_RESET && cpu_clk_en;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset vector not loaded"); // R5

  property p_irq_wake;
    @(posedge aclk) disable iff (!aresetn)
      (state == ST_WAIT && irq_fall && irq_req == '0 && pend == '0 && !rst_src)
        |=> vector_load && vector_addr == VEC_TAB[SRC_IRQ] ##1 !vector_load;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("irq wake vector wrong"); // R6

  property p_rec_len;
    @(posedge aclk) disable iff (!aresetn)
      (state == ST_RECOVER && next_state == ST_RUN)
        |-> rec_seen == (rec_short ? (REC_W+1)'(REC_SHORT - 1) : (REC_W+1)'(REC_LONG - 1));
  endproperty
  a_rec_len: assert property (p_rec_len) else $error("recovery length wrong"); // R18

  property p_rec_quiet;
    @(posedge aclk) disable iff (!aresetn)
      (state == ST_RECOVER) |-> !vector_load && !sys_clk_en;
  endproperty
  a_rec_quiet: assert property (p_rec_quiet) else $error("clocks during recovery"); // R24

  property p_low_set;
    @(posedge aclk) disable iff (!aresetn)
      (cmp_below_falling && supply_monitor_enable) |=> supply_low;
  endproperty
  a_low_set: assert property (p_low_set) else $error("supply low not set"); // R23

  property p_hold_pin;
    @(posedge aclk) disable iff (!aresetn)
      hold |-> reset_pin_oe ##1 device_reset;
  endproperty
  a_hold_pin: assert property (p_hold_pin) else $error("supply reset not driven"); // R21

  property p_trip_rise;
    @(posedge aclk) disable iff (!aresetn)
      ($rose(trip_level_select) && !$past(cmp_above_rising) && $past(supply_monitor_enable))
        |-> hold;
  endproperty
  a_trip_rise: assert property (p_trip_rise) else $error("5 V select missed reset"); // R22

endmodule : lpws_top
`default_nettype wire

// *** rtl/lpws_pkg.sv ***
// constants, register map and types of the low power wake sequencer
package lpws_pkg;
  // wake source indices, vector table order (lowest index wins)
  localparam int SRC_N = 21;
  localparam int SRC_BRK = 0;
  localparam int SRC_IRQ = 1;
  localparam int SRC_KBI = 14;
  localparam int SRC_PWT = 16;
  localparam int SRC_CANWK = 17;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  // high byte address of each source vector pair
  localparam logic [15:0] VEC_TAB [SRC_N] = '{
    16'hFFFC, 16'hFFFA, 16'hFFF8, 16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFF0,
    16'hFFEE, 16'hFFEC, 16'hFFEA, 16'hFFE8, 16'hFFE6, 16'hFFE4, 16'hFFE2,
    16'hFFE0, 16'hFFDE, 16'hFFDC, 16'hFFDA, 16'hFFD8, 16'hFFD6, 16'hFFD4};
  // sources able to end stop: irq pin, keypad, wake timer, can wakeup
  localparam logic [SRC_N-1:0] STOP_WAKE = 21'h034002;
  // stop recovery lengths in reference clock cycles
  localparam int REC_LONG_CYC = 4096;
  localparam int REC_SHORT_CYC = 32;
  localparam int REC_W = 12;
  // register byte addresses
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_VEC = 4'h8;
  localparam logic [3:0] REG_PEND = 4'hC;
  // control register fields
  localparam int CB_OSC = 0;
  localparam int CB_SSR = 1;
  localparam int CB_PWRD = 2;
  localparam int CB_RSTD = 3;
  localparam int CB_STOPEN = 4;
  localparam int CB_TRIP = 5;
  localparam int CTRL_W = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
  // status register fields
  localparam int SB_LOW = 0;
  localparam int SB_HOLD = 1;
  localparam int SB_STATE = 2;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [2:0] {ST_RUN, ST_WAIT, ST_STOP, ST_RECOVER, ST_RESET} lpws_state_t;
endpackage : lpws_pkg

// *** tb/lpws_cpu_model.sv ***
// model of the cpu core and the peripheral request sources
`timescale 1ns/1ns
`default_nettype none
module lpws_cpu_model
  import lpws_pkg::*;
(
  input wire logic aclk,
  input wire logic vector_load,
  input wire logic [15:0] vector_addr,
  input wire logic sys_clk_en,
  output logic cpu_wait_req,
  output logic cpu_stop_req,
  output logic [SRC_N-1:0] irq_req,
  output logic can_sync_ok
);
  logic [2:0] sync_q = 3'h0; // clocks-on history
  initial begin
    cpu_wait_req = 1'b0;
    cpu_stop_req = 1'b0;
    irq_req = '0;
  end
  // one cycle sleep pulse, stop when s is set
  task automatic sleep(input logic s);
    cpu_wait_req <= !s;
    cpu_stop_req <= s;
    @(posedge aclk);
    cpu_wait_req <= 1'b0;
    cpu_stop_req <= 1'b0;
    @(posedge aclk);
  endtask : sleep
  // set or drop one request line
  task automatic raise(input int s, input logic v);
    irq_req[s] <= v;
  endtask : raise
  // a request stays up until its own vector is loaded
  always @(posedge aclk) begin
    if (vector_load) begin
      for (int i = 0; i < SRC_N; i++) begin
        if (VEC_TAB[i] == vector_addr) irq_req[i] <= 1'b0;
      end
    end
  end
  // bit sync comes back a few cycles after the clocks
  always @(posedge aclk) sync_q <= {sync_q[1:0], sys_clk_en};
  assign can_sync_ok = sync_q[2];
endmodule : lpws_cpu_model
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench of the low power wake sequencer
`timescale 1ns/1ns
`default_nettype none
module testbench
  import lpws_pkg::*;
;
  localparam int NL = 40; // shortened long recovery
  localparam int NS = 8; // shortened short recovery
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rv;
  logic [1:0] bresp, rresp, rsp;
  logic reset_pin_in_n, reset_pin_out, reset_pin_oe, watchdog_timeout;
  logic emulation_mode, irq_pin, cpu_wait_req, cpu_stop_req, can_sync_ok;
  logic cmp_below_falling, cmp_above_rising, cpu_clk_en, sys_clk_en;
  logic vector_load, device_reset, pwt_run, pwt_reg_access, can_active;
  logic can_reg_access, can_rx_enable, supply_monitor_enable;
  logic trip_level_select, osc_run_in_stop;
  logic [15:0] vector_addr;
  logic [SRC_N-1:0] irq_req;
  int errors, comparisons, n;
  lpws_top #(.REC_LONG(NL), .REC_SHORT(NS)) DUT (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .reset_pin_in_n, .reset_pin_out, .reset_pin_oe,
    .watchdog_timeout, .emulation_mode, .irq_pin, .irq_req, .cpu_wait_req,
    .cpu_stop_req, .can_sync_ok, .cmp_below_falling, .cmp_above_rising,
    .cpu_clk_en, .sys_clk_en, .vector_load, .vector_addr, .device_reset,
    .pwt_run, .pwt_reg_access, .can_active, .can_reg_access, .can_rx_enable,
    .supply_monitor_enable, .trip_level_select, .osc_run_in_stop);
  lpws_cpu_model cpu (
    .aclk, .vector_load, .vector_addr, .sys_clk_en, .cpu_wait_req,
    .cpu_stop_req, .irq_req, .can_sync_ok);
  // 25 MHz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // bus write, address and data offered together
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
    // let an edge pass so a following call never re-raises bready in this step
    @(posedge aclk);
  endtask : wr
  // bus read
  task automatic rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rv = rdata;
    rsp = rresp;
    rready <= 1'b0;
    // let an edge pass so a following call never re-raises rready in this step
    @(posedge aclk);
  endtask : rd
  // wait for a vector load, counting cycles into n
  task automatic wload(input int lim);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!vector_load && n < lim);
    chk(vector_load, 1'b1);
  endtask : wload
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(REG_CTRL);
    chk(rv, 32'h0);
    chk(trip_level_select, 1'b0);
    chk(supply_monitor_enable, 1'b1);
    wr(REG_CTRL, 32'h4);
    repeat (2) @(posedge aclk);
    chk(supply_monitor_enable, 1'b0);
    wr(REG_STAT, 32'h1);
    chk(rsp, RESP_SLVERR);
    wr(REG_CTRL, 32'h0);
    // write without the low lane must leave control untouched
    wstrb <= 4'hE;
    wr(REG_CTRL, 32'h4);
    wstrb <= 4'hF;
    rd(REG_CTRL);
    chk(rv, 32'h0);
    // unmapped read answers with a decode error
    rd(4'h2);
    chk(rsp, RESP_DECERR);
  endtask : t_regs
  // every source wakes wait mode through its own vector pair
  task automatic t_wait;
    for (int s = 0; s < SRC_N; s++) begin
      cpu.sleep(1'b0);
      chk(cpu_clk_en, 1'b0);
      chk({can_active, can_reg_access}, 2'h2);
      cpu.raise(s, 1'b1);
      // break outside emulation must not end wait
      if (s == SRC_BRK) begin
        emulation_mode <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(cpu_clk_en, 1'b0);
        emulation_mode <= 1'b1;
      end
      wload(10);
      chk(vector_addr, VEC_TAB[s]);
      chk(cpu_clk_en, 1'b1);
    end
    // falling edge on the irq pin ends wait
    cpu.sleep(1'b0);
    irq_pin <= 1'b0;
    wload(10);
    chk(vector_addr, 16'hFFFA);
    irq_pin <= 1'b1;
  endtask : t_wait
  // stop: refused sources, then pin edge with long recovery
  task automatic t_stop;
    cpu.sleep(1'b1);
    cpu.raise(SRC_PWT, 1'b1);
    cpu.raise(SRC_N - 1, 1'b1);
    repeat (20) @(posedge aclk);
    chk({sys_clk_en, pwt_run, pwt_reg_access, can_active}, 4'h0);
    irq_pin <= 1'b0;
    wload(NL + 10);
    chk(n >= NL + 1 && n <= NL + 5, 1'b1);
    chk(vector_addr, 16'hFFFA);
    irq_pin <= 1'b1;
  endtask : t_stop
  // stop with oscillator on and short recovery
  task automatic t_short;
    wr(REG_CTRL, 32'h3);
    chk(osc_run_in_stop, 1'b1);
    cpu.sleep(1'b1);
    wload(NS + 20);
    chk(vector_addr, 16'hFFDC);
    cpu.sleep(1'b1);
    cpu.raise(SRC_KBI, 1'b1);
    wload(NS + 10);
    chk(n >= NS + 1 && n <= NS + 5, 1'b1);
    chk(vector_addr, 16'hFFE0);
    cpu.sleep(1'b1);
    cpu.raise(SRC_CANWK, 1'b1);
    @(posedge aclk);
    chk(can_rx_enable, 1'b0);
    wload(NS + 10);
    chk(vector_addr, 16'hFFDA);
    cpu.sleep(1'b0);
    wload(10);
    chk(vector_addr, 16'hFFD4);
  endtask : t_short
  // supply monitor reset, hold and status flag
  task automatic t_supply;
    cmp_above_rising <= 1'b0;
    wr(REG_CTRL, 32'h20);
    repeat (4) @(posedge aclk);
    chk({reset_pin_oe, reset_pin_out, device_reset}, 3'h5);
    cmp_above_rising <= 1'b1;
    wload(20);
    chk(vector_addr, VEC_RESET);
    wr(REG_CTRL, 32'h8);
    cmp_below_falling <= 1'b1;
    cmp_above_rising <= 1'b0;
    // flag needs one edge to follow the comparator before the read
    @(posedge aclk);
    rd(REG_STAT);
    chk(rv[0], 1'b1);
    cmp_below_falling <= 1'b0;
    rd(REG_STAT);
    chk(rv[0], 1'b1);
    cmp_above_rising <= 1'b1;
    rd(REG_STAT);
    rd(REG_STAT);
    chk({rv[0], device_reset}, 2'h0);
  endtask : t_supply
  // watchdog and reset pin restart through the reset vector
  task automatic t_resets;
    for (int k = 0; k < 2; k++) begin
      watchdog_timeout <= (k == 0);
      reset_pin_in_n <= (k == 0);
      @(posedge aclk);
      watchdog_timeout <= 1'b0;
      reset_pin_in_n <= 1'b1;
      wload(20);
      chk(vector_addr, VEC_RESET);
    end
  endtask : t_resets
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    errors = 0;
    comparisons = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {watchdog_timeout, cmp_below_falling} = '0;
    {reset_pin_in_n, emulation_mode, irq_pin, cmp_above_rising} = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    wload(5);
    chk(vector_addr, VEC_RESET);
    @(posedge aclk);
    t_regs();
    t_wait();
    t_stop();
    t_short();
    t_supply();
    t_resets();
    final_report();
  end
  // hang guard
  initial begin
    #800000;
    errors++;
    final_report();
  end
endmodule : testbench
`default_nettype wire
